// ==== logic/adcch_pkg.sv ====
/*
  Shared constants and carrier types of the channel setup register bank.
  Assumes one clock domain; all control port signals are on that clock.
*/
`default_nettype none
package adcch_pkg;
  // Register page and byte addresses on that page.
  localparam logic [7:0] ADCCH_PAGE = 8'h00;
  localparam logic [7:0] ADCCH_OFF_VOLUME = 8'h48;
  localparam logic [7:0] ADCCH_OFF_TRIM = 8'h49;
  localparam logic [7:0] ADCCH_OFF_PHASE = 8'h4A;
  localparam logic [7:0] ADCCH_OFF_INSETUP = 8'h4B;
  localparam logic [7:0] ADCCH_OFF_AGAIN = 8'h4C;
  // Reset values.
  localparam logic [7:0] ADCCH_RST_VOLUME = 8'hC9;
  localparam logic [7:0] ADCCH_RST_TRIM = 8'h80;
  localparam logic [7:0] ADCCH_RST_PHASE = 8'h00;
  localparam logic [7:0] ADCCH_RST_INSETUP = 8'h00;
  localparam logic [7:0] ADCCH_RST_AGAIN = 8'h00;
  // Writable bits; the rest are reserved and stay zero.
  localparam logic [7:0] ADCCH_MASK_TRIM = 8'hF0;
  localparam logic [7:0] ADCCH_MASK_INSETUP = 8'hFD;
  localparam logic [7:0] ADCCH_MASK_AGAIN = 8'hFC;
  // Field positions.
  localparam int ADCCH_TRIM_LSB = 4;
  localparam int ADCCH_KIND_BIT = 7;
  localparam int ADCCH_SRC_LSB = 5;
  localparam int ADCCH_DC_BIT = 4;
  localparam int ADCCH_IMP_LSB = 2;
  localparam int ADCCH_BOOST_BIT = 0;
  localparam int ADCCH_AGAIN_LSB = 2;
  // Code points.
  localparam logic [7:0] ADCCH_VOL_MUTE = 8'h00;
  localparam logic signed [8:0] ADCCH_VOL_UNITY = 9'sh0C9;
  localparam logic signed [4:0] ADCCH_TRIM_UNITY = 5'sh08;
  localparam logic [1:0] ADCCH_IMP_RSVD = 2'h3;
  localparam logic [5:0] ADCCH_AGAIN_MAX = 6'h2A;

  typedef enum logic [1:0] {
    ADCCH_SRC_DIFF = 2'h0,
    ADCCH_SRC_SINGLE = 2'h1,
    ADCCH_SRC_PDM = 2'h2,
    ADCCH_SRC_RSVD = 2'h3
  } adcch_src_e;

  typedef struct packed {
    logic mute;
    logic signed [8:0] volume_half_db;
    logic [7:0] third_channel_volume_code;
    logic [3:0] third_channel_gain_trim;
    logic signed [4:0] trim_tenth_db;
    logic [7:0] third_channel_phase_delay;
  } adcch_ch3_s;

  typedef struct packed {
    logic fourth_channel_input_kind;
    adcch_src_e fourth_channel_source_select;
    logic source_reserved;
    logic fourth_channel_coupling_select;
    logic [1:0] fourth_channel_impedance_select;
    logic impedance_reserved;
    logic fourth_channel_range_boost_enable;
    logic dynamic_range_enhancer;
    logic automatic_gain_control;
    logic [5:0] fourth_channel_analog_gain;
    logic gain_reserved;
  } adcch_ch4_s;
endpackage : adcch_pkg
`default_nettype wire

// ==== logic/adcch_delay_mem.sv ====
/*
  Phase delay line: a circular sample memory with a registered read port.
  Assumes tick marks one modulator clock cycle on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module adcch_delay_mem #(
  parameter int WIDTH = 1,
  parameter int ABITS = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Sample stream.
  input wire logic tick,
  input wire logic [ABITS-1:0] delay,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout,
  output logic dout_valid
);
  logic [WIDTH-1:0] mem [0:(1<<ABITS)-1];
  logic [ABITS-1:0] wptr_q, wptr_d;
  logic [WIDTH-1:0] dout_q, dout_d;
  logic valid_q, valid_d;
  logic [ABITS-1:0] raddr;

  assign raddr = wptr_q - delay;

  always_comb begin
    wptr_d = wptr_q;
    dout_d = dout_q;
    valid_d = tick;
    if (tick) begin
      wptr_d = wptr_q + 1'b1;
      // A zero delay bypasses the memory, whose slot is being written now.
      dout_d = (delay == '0) ? din : mem[raddr]; // RQ5
    end
  end

  always_ff @(posedge clk) begin
    if (tick) begin
      mem[wptr_q] <= din;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_q <= '0;
      dout_q <= '0;
      valid_q <= 1'b0;
    end else begin
      wptr_q <= wptr_d;
      dout_q <= dout_d;
      valid_q <= valid_d;
    end
  end

  assign dout = dout_q;
  assign dout_valid = valid_q;

  a_delay_bypass: assert property (@(posedge clk) disable iff (rst)
    tick && delay == '0 |=> dout == $past(din) && dout_valid) // RQ5
    else $error("zero delay did not pass the sample straight through");
endmodule : adcch_delay_mem
`default_nettype wire

// ==== logic/adcch_setup_regs.sv ====
/*
  Channel setup register bank: channel 3 volume, trim and phase delay,
  channel 4 input setup and analog gain, with a phase delay line.
  Assumes the control port and the range boost mode bit are on REF_CLK.
*/
// Functional notes
// RQ1 - Volume zero mutes; codes step half dB
// RQ2 - Volume resets to unity code C9
// RQ3 - Gain trim steps tenth dB, 8 unity
// RQ4 - Gain trim field resets to eight
// RQ5 - Phase value delays N modulator cycles
// RQ6 - Bit seven picks microphone or line
// RQ7 - Source field picks differential, single, PDM
// RQ8 - Software frees shared pins for analog
// RQ9 - Software routes shared pins for PDM
// RQ10 - Bit four coupling, analog sources only
// RQ11 - Impedance field selects input impedance
// RQ12 - Bit zero enables enhancer or gain control
// RQ13 - Registers live on page zero
// RQ14 - Analog gain zero to 42 dB
// RQ15 - Reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module adcch_setup_regs
  import adcch_pkg::*;
#(
  parameter int SAMPLE_WIDTH = 1,
  parameter int DELAY_BITS = 8
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RESET,
  // Control port.
  input wire logic [7:0] CTRL_PAGE,
  input wire logic [7:0] CTRL_ADDR,
  input wire logic [7:0] CTRL_WDATA,
  input wire logic CTRL_WR,
  input wire logic CTRL_RD,
  output logic [7:0] CTRL_RDATA,
  output logic CTRL_RVALID,
  // Mode bit from the range boost mode register.
  input wire logic RANGE_BOOST_MODE_SEL,
  // Channel 3 sample stream.
  input wire logic MOD_TICK,
  input wire logic [SAMPLE_WIDTH-1:0] CH3_SAMPLE_IN,
  output logic [SAMPLE_WIDTH-1:0] CH3_SAMPLE_OUT,
  output logic CH3_SAMPLE_VALID,
  // Decoded settings.
  output adcch_ch3_s CH3_SETTINGS,
  output adcch_ch4_s CH4_SETTINGS
);
  logic [7:0] vol_q, vol_d;
  logic [7:0] trim_q, trim_d;
  logic [7:0] phase_q, phase_d;
  logic [7:0] insetup_q, insetup_d;
  logic [7:0] again_q, again_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  adcch_ch3_s ch3_q, ch3_d;
  adcch_ch4_s ch4_q, ch4_d;
  logic on_page;
  logic is_analog;
  adcch_src_e src;

  // Writes to any other page are ignored; reads there still answer, with zero.
  assign on_page = (CTRL_PAGE == ADCCH_PAGE); // RQ13

  // Register writes; only writable bits are kept.
  always_comb begin
    vol_d = vol_q;
    trim_d = trim_q;
    phase_d = phase_q;
    insetup_d = insetup_q;
    again_d = again_q;
    if (CTRL_WR && on_page) begin
      unique case (CTRL_ADDR)
        ADCCH_OFF_VOLUME: vol_d = CTRL_WDATA;
        ADCCH_OFF_TRIM: trim_d = CTRL_WDATA & ADCCH_MASK_TRIM; // RQ15
        ADCCH_OFF_PHASE: phase_d = CTRL_WDATA;
        ADCCH_OFF_INSETUP: insetup_d = CTRL_WDATA & ADCCH_MASK_INSETUP; // RQ15
        ADCCH_OFF_AGAIN: again_d = CTRL_WDATA & ADCCH_MASK_AGAIN; // RQ15
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      vol_q <= ADCCH_RST_VOLUME; // RQ2
      trim_q <= ADCCH_RST_TRIM; // RQ4
      phase_q <= ADCCH_RST_PHASE; // RQ5
      insetup_q <= ADCCH_RST_INSETUP;
      again_q <= ADCCH_RST_AGAIN;
    end else begin
      vol_q <= vol_d;
      trim_q <= trim_d;
      phase_q <= phase_d;
      insetup_q <= insetup_d;
      again_q <= again_d;
    end
  end

  // Read port; unmapped addresses and other pages read zero.
  always_comb begin
    rvalid_d = CTRL_RD;
    rdata_d = rdata_q;
    if (CTRL_RD) begin
      rdata_d = 8'h00;
      if (on_page) begin
        unique case (CTRL_ADDR)
          ADCCH_OFF_VOLUME: rdata_d = vol_q;
          ADCCH_OFF_TRIM: rdata_d = trim_q;
          ADCCH_OFF_PHASE: rdata_d = phase_q;
          ADCCH_OFF_INSETUP: rdata_d = insetup_q;
          ADCCH_OFF_AGAIN: rdata_d = again_q;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign CTRL_RDATA = rdata_q;
  assign CTRL_RVALID = rvalid_q;

  // Settings decode. Registered so that the outputs are glitch free.
  assign src = adcch_src_e'(insetup_q[ADCCH_SRC_LSB +: 2]);
  assign is_analog = (src == ADCCH_SRC_DIFF) || (src == ADCCH_SRC_SINGLE);

  always_comb begin
    ch3_d.third_channel_volume_code = vol_q;
    ch3_d.mute = (vol_q == ADCCH_VOL_MUTE); // RQ1
    ch3_d.volume_half_db = $signed({1'b0, vol_q}) - ADCCH_VOL_UNITY; // RQ1
    ch3_d.third_channel_gain_trim = trim_q[ADCCH_TRIM_LSB +: 4];
    ch3_d.trim_tenth_db = $signed({1'b0, trim_q[ADCCH_TRIM_LSB +: 4]})
                          - ADCCH_TRIM_UNITY; // RQ3
    ch3_d.third_channel_phase_delay = phase_q;
    ch4_d.fourth_channel_input_kind = insetup_q[ADCCH_KIND_BIT]; // RQ6
    ch4_d.fourth_channel_source_select = src; // RQ7
    ch4_d.source_reserved = (src == ADCCH_SRC_RSVD); // RQ7
    // Coupling means nothing for a digital stream, so it is forced to AC there.
    ch4_d.fourth_channel_coupling_select = insetup_q[ADCCH_DC_BIT] && is_analog; // RQ10
    ch4_d.fourth_channel_impedance_select = insetup_q[ADCCH_IMP_LSB +: 2]; // RQ11
    ch4_d.impedance_reserved = (insetup_q[ADCCH_IMP_LSB +: 2] == ADCCH_IMP_RSVD); // RQ11
    ch4_d.fourth_channel_range_boost_enable = insetup_q[ADCCH_BOOST_BIT];
    ch4_d.dynamic_range_enhancer = insetup_q[ADCCH_BOOST_BIT] && !RANGE_BOOST_MODE_SEL; // RQ12
    ch4_d.automatic_gain_control = insetup_q[ADCCH_BOOST_BIT] && RANGE_BOOST_MODE_SEL; // RQ12
    // Reserved gain codes are clamped to the top legal step and flagged.
    ch4_d.gain_reserved = (again_q[ADCCH_AGAIN_LSB +: 6] > ADCCH_AGAIN_MAX); // RQ14
    ch4_d.fourth_channel_analog_gain = ch4_d.gain_reserved ? ADCCH_AGAIN_MAX
                                       : again_q[ADCCH_AGAIN_LSB +: 6]; // RQ14
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      ch3_q <= '0;
      ch4_q <= '0;
    end else begin
      ch3_q <= ch3_d;
      ch4_q <= ch4_d;
    end
  end

  assign CH3_SETTINGS = ch3_q;
  assign CH4_SETTINGS = ch4_q;

  // Phase delay in modulator cycles.
  adcch_delay_mem #(
    .WIDTH(SAMPLE_WIDTH),
    .ABITS(DELAY_BITS)
  ) u_delay (
    .clk(REF_CLK),
    .rst(RESET),
    .tick(MOD_TICK),
    .delay(phase_q[DELAY_BITS-1:0]), // RQ5
    .din(CH3_SAMPLE_IN),
    .dout(CH3_SAMPLE_OUT),
    .dout_valid(CH3_SAMPLE_VALID)
  );

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence s_write(logic [7:0] addr);
    CTRL_WR && on_page && CTRL_ADDR == addr;
  endsequence

  a_vol_mute_code: assert property ( // RQ1
    s_write(ADCCH_OFF_VOLUME) ##2 1'b1 |-> CH3_SETTINGS.mute == ($past(CTRL_WDATA, 2) == 8'h00)
      && CH3_SETTINGS.volume_half_db == $signed({1'b0, $past(CTRL_WDATA, 2)}) - 9'sd201)
    else $error("volume decode does not follow the written code");

  a_vol_reset_value: assert property ($past(RESET) |-> vol_q == 8'hC9) // RQ2
    else $error("volume code did not come out of reset at unity");

  a_trim_decode: assert property ( // RQ3
    s_write(ADCCH_OFF_TRIM) |-> ##2 CH3_SETTINGS.trim_tenth_db
      == $signed({1'b0, $past(CTRL_WDATA[7:4], 2)}) - 5'sd8)
    else $error("gain trim decode is off");

  a_trim_reset: assert property ($past(RESET) |-> trim_q[7:4] == 4'h8) // RQ4
    else $error("gain trim did not reset to eight");

  a_phase_write: assert property ( // RQ5
    s_write(ADCCH_OFF_PHASE) |=> phase_q == $past(CTRL_WDATA))
    else $error("phase delay value not stored");

  a_kind_follow: assert property ( // RQ6
    s_write(ADCCH_OFF_INSETUP) |-> ##2 CH4_SETTINGS.fourth_channel_input_kind
      == $past(CTRL_WDATA[7], 2))
    else $error("input kind does not follow bit seven");

  a_src_reserved: assert property ( // RQ7
    CH4_SETTINGS.source_reserved |-> CH4_SETTINGS.fourth_channel_source_select == ADCCH_SRC_RSVD)
    else $error("reserved source flag without reserved code");

  a_pdm_no_dc: assert property ( // RQ10
    CH4_SETTINGS.fourth_channel_source_select == ADCCH_SRC_PDM
      |-> !CH4_SETTINGS.fourth_channel_coupling_select)
    else $error("coupling applied to the digital source");

  a_imp_reserved: assert property ( // RQ11
    CH4_SETTINGS.impedance_reserved == (CH4_SETTINGS.fourth_channel_impedance_select == 2'h3))
    else $error("impedance reserved flag wrong");

  a_boost_pick: assert property ( // RQ12
    ##1 CH4_SETTINGS.dynamic_range_enhancer
      == ($past(insetup_q[0]) && !$past(RANGE_BOOST_MODE_SEL))
      && !(CH4_SETTINGS.dynamic_range_enhancer && CH4_SETTINGS.automatic_gain_control))
    else $error("enhancer and gain control selection wrong");

  a_page_other: assert property ( // RQ13
    CTRL_WR && !on_page |=> $stable(vol_q) && $stable(insetup_q) && $stable(phase_q))
    else $error("write on another page changed a register");

  a_gain_clamp: assert property ( // RQ14
    CH4_SETTINGS.fourth_channel_analog_gain <= 6'd42)
    else $error("analog gain above 42 dB");

  a_rsvd_read_zero: assert property ( // RQ15
    CTRL_RD && on_page && CTRL_ADDR == ADCCH_OFF_TRIM |=> CTRL_RVALID && CTRL_RDATA[3:0] == 4'h0)
    else $error("reserved trim bits read nonzero");
endmodule : adcch_setup_regs
`default_nettype wire

// ==== verification/adcch_setup_regs_tb.sv ====
/*
  Self-checking bench for the channel setup register bank.
  Assumes the bank answers reads one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("Error %0t: %s got %h exp %h", $time, m, g, e); end end
module adcch_setup_regs_tb;
  import adcch_pkg::*;
  logic REF_CLK = 1'b0;
  logic RESET = 1'b1;
  logic [7:0] CTRL_PAGE = 8'h00, CTRL_ADDR = 8'h00, CTRL_WDATA = 8'h00;
  logic CTRL_WR = 1'b0, CTRL_RD = 1'b0, RANGE_BOOST_MODE_SEL = 1'b0;
  logic MOD_TICK = 1'b0, CH3_SAMPLE_IN = 1'b0;
  logic [7:0] CTRL_RDATA;
  logic CTRL_RVALID, CH3_SAMPLE_OUT, CH3_SAMPLE_VALID;
  adcch_ch3_s CH3_SETTINGS;
  adcch_ch4_s CH4_SETTINGS;
  int err_total = 0;
  int checks_done = 0;
  logic [7:0] rq[$];
  logic [1:0] sq[$];
  logic [7:0] mdl[5];
  logic [7:0] msk[5] = '{8'hFF, ADCCH_MASK_TRIM, 8'hFF, ADCCH_MASK_INSETUP, ADCCH_MASK_AGAIN};
  logic [7:0] hist[$];
  int vc[4] = '{0, 1, 201, 255};
  int k, n;
  logic smp;

  adcch_setup_regs u_adcch_setup_regs (
    .REF_CLK(REF_CLK), .RESET(RESET), .CTRL_PAGE(CTRL_PAGE), .CTRL_ADDR(CTRL_ADDR),
    .CTRL_WDATA(CTRL_WDATA), .CTRL_WR(CTRL_WR), .CTRL_RD(CTRL_RD), .CTRL_RDATA(CTRL_RDATA),
    .CTRL_RVALID(CTRL_RVALID), .RANGE_BOOST_MODE_SEL(RANGE_BOOST_MODE_SEL),
    .MOD_TICK(MOD_TICK), .CH3_SAMPLE_IN(CH3_SAMPLE_IN), .CH3_SAMPLE_OUT(CH3_SAMPLE_OUT),
    .CH3_SAMPLE_VALID(CH3_SAMPLE_VALID), .CH3_SETTINGS(CH3_SETTINGS),
    .CH4_SETTINGS(CH4_SETTINGS)
  );

  initial begin
    forever #50 REF_CLK = ~REF_CLK;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // Writes through the page-0 window also update the bench's image of the bank.
  task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    CTRL_PAGE <= pg;
    CTRL_ADDR <= a;
    CTRL_WDATA <= d;
    CTRL_WR <= 1'b1;
    if (pg == ADCCH_PAGE && a >= 8'h48 && a <= 8'h4C) mdl[a - 8'h48] = d & msk[a - 8'h48];
    @(posedge REF_CLK);
    CTRL_WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge REF_CLK);
    CTRL_PAGE <= ADCCH_PAGE;
    CTRL_ADDR <= a;
    CTRL_RD <= 1'b1;
    rq.push_back((a >= 8'h48 && a <= 8'h4C) ? mdl[a - 8'h48] : 8'h00);
    @(posedge REF_CLK);
    CTRL_RD <= 1'b0;
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge REF_CLK);
    @(negedge REF_CLK);
  endtask : settle

  task automatic drain;
    for (int i = 0; i < 20 && (rq.size() != 0 || sq.size() != 0); i++) @(posedge REF_CLK);
    if (rq.size() != 0 || sq.size() != 0) begin
      err_total++;
      close_out();
    end
  endtask : drain

  // Outputs are judged on the falling edge, where every registered value has settled.
  always @(negedge REF_CLK) begin
    if (CTRL_RVALID === 1'b1) begin
      if (rq.size() == 0) begin
        err_total++;
        $display("Error %0t: unexpected read answer", $time);
      end else begin
        `CHK(CTRL_RDATA, rq.pop_front(), "read data")
      end
    end
    if (CH3_SAMPLE_VALID === 1'b1 && sq.size() != 0) begin
      if (sq[0][1]) begin
        `CHK(CH3_SAMPLE_OUT, sq[0][0], "delayed sample")
      end
      void'(sq.pop_front());
    end
  end

  initial begin
    repeat (60000) @(posedge REF_CLK);
    err_total++;
    close_out();
  end

  initial begin
    void'($urandom(378));
    mdl = '{ADCCH_RST_VOLUME, ADCCH_RST_TRIM, ADCCH_RST_PHASE, ADCCH_RST_INSETUP,
      ADCCH_RST_AGAIN};
    repeat (3) @(posedge REF_CLK);
    RESET <= 1'b0;
    for (int a = 8'h47; a <= 8'h4D; a++) rd(8'(a));
    drain();
    $display("reset values done");
    for (int a = 8'h48; a <= 8'h4D; a++) wr(ADCCH_PAGE, 8'(a), 8'hFF);
    wr(8'h01, ADCCH_OFF_PHASE, 8'h00);
    for (int a = 8'h48; a <= 8'h4D; a++) rd(8'(a));
    for (int i = 0; i < 10; i++) wr(ADCCH_PAGE, 8'(8'h48 + $urandom % 5), 8'($urandom));
    for (int a = 8'h48; a <= 8'h4C; a++) rd(8'(a));
    drain();
    $display("access and masking done");
    foreach (vc[i]) begin
      wr(ADCCH_PAGE, ADCCH_OFF_VOLUME, 8'(vc[i]));
      settle();
      `CHK(CH3_SETTINGS.mute, 1'(vc[i] == 0), "mute")
      if (vc[i] != 0) `CHK(CH3_SETTINGS.volume_half_db, 9'(vc[i] - 201), "volume")
      wr(ADCCH_PAGE, ADCCH_OFF_TRIM, 8'(i * 5) << 4);
      settle();
      `CHK(CH3_SETTINGS.trim_tenth_db, 5'(i * 5 - 8), "trim")
    end
    $display("channel 3 decode done");
    wr(ADCCH_PAGE, ADCCH_OFF_INSETUP, 8'hC1);
    settle();
    `CHK({CH4_SETTINGS.fourth_channel_input_kind, CH4_SETTINGS.fourth_channel_source_select},
      3'h6, "kind and source")
    `CHK({CH4_SETTINGS.dynamic_range_enhancer, CH4_SETTINGS.automatic_gain_control},
      2'h2, "enhancer pick")
    @(posedge REF_CLK);
    RANGE_BOOST_MODE_SEL <= 1'b1;
    settle();
    `CHK({CH4_SETTINGS.dynamic_range_enhancer, CH4_SETTINGS.automatic_gain_control},
      2'h1, "gain control pick")
    wr(ADCCH_PAGE, ADCCH_OFF_INSETUP, 8'h5C);
    settle();
    `CHK(CH4_SETTINGS.impedance_reserved, 1'b1, "impedance flag")
    `CHK(CH4_SETTINGS.source_reserved, 1'b0, "source flag clear")
    `CHK(CH4_SETTINGS.fourth_channel_coupling_select, 1'b0, "pdm coupling")
    `CHK({CH4_SETTINGS.dynamic_range_enhancer, CH4_SETTINGS.automatic_gain_control},
      2'h0, "boost off")
    for (int s = 0; s < 2; s++) begin
      wr(ADCCH_PAGE, ADCCH_OFF_INSETUP, 8'(8'h18 | (s << 5) | (s << 2)));
      settle();
      `CHK(CH4_SETTINGS.impedance_reserved, 1'(s), "impedance flag")
      `CHK(CH4_SETTINGS.fourth_channel_coupling_select, 1'b1, "dc coupling")
      `CHK(CH4_SETTINGS.fourth_channel_impedance_select, 2'(2 + s), "impedance")
    end
    wr(ADCCH_PAGE, ADCCH_OFF_INSETUP, 8'h60);
    settle();
    `CHK(CH4_SETTINGS.source_reserved, 1'b1, "source reserved")
    wr(ADCCH_PAGE, ADCCH_OFF_AGAIN, 8'hA8);
    settle();
    `CHK(CH4_SETTINGS.fourth_channel_analog_gain, ADCCH_AGAIN_MAX, "gain 42")
    `CHK(CH4_SETTINGS.gain_reserved, 1'b0, "gain 42 flag")
    wr(ADCCH_PAGE, ADCCH_OFF_AGAIN, 8'hFC);
    settle();
    `CHK(CH4_SETTINGS.fourth_channel_analog_gain, ADCCH_AGAIN_MAX, "gain clamp")
    `CHK(CH4_SETTINGS.gain_reserved, 1'b1, "gain flag")
    $display("channel 4 decode done");
    foreach (vc[i]) begin
      // The delay memory is uninitialised, so only ticks with full history are judged.
      n = (vc[i] == 201) ? 2 : vc[i];
      wr(ADCCH_PAGE, ADCCH_OFF_PHASE, 8'(n));
      hist.delete();
      for (k = 0; k < 300; k++) begin
        @(posedge REF_CLK);
        MOD_TICK <= 1'b1;
        smp = 1'($urandom);
        CH3_SAMPLE_IN <= smp;
        hist.push_front({7'h00, smp});
        if (k >= n) sq.push_back({1'b1, hist[n][0]});
        else sq.push_back(2'b00);
        if (k % 3 == 2) begin
          @(posedge REF_CLK);
          MOD_TICK <= 1'b0;
        end
      end
      @(posedge REF_CLK);
      MOD_TICK <= 1'b0;
      drain();
    end
    $display("phase delay done");
    close_out();
  end
endmodule : adcch_setup_regs_tb
`default_nettype wire
